//--- dv/usb_ctrl_props.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module usb_ctrl_props (
  input wire        i_clk,         // clock
  input wire        i_resetn,      // reset, low
  input wire        i_bready,      // b ready
  input wire        i_rready,      // r ready
  input wire        i_rx_done,     // char done
  input wire        o_bvalid,      // b valid
  input wire [1:0]  o_bresp,       // b response
  input wire        o_rvalid,      // r valid
  input wire [31:0] o_rdata,       // r data
  input wire        o_baud_tick,   // bit tick
  input wire        o_port_active, // port on
  input wire        o_sync_mode,   // sync mode
  input wire        o_sync_master, // clock master
  input wire        o_tx_run,      // tx allowed
  input wire        o_rx_run,      // rx on
  input wire        o_rx_load,     // buffer load
  input wire        o_rx_irq,      // rx flag
  input wire        o_send_break   // break next
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // bit timer and receive path
  a_tick_gap: assert property (o_baud_tick |=> !o_baud_tick [*3])
    else $error("ticks too close");
  a_load_cause: assert property (o_rx_load |-> $past(i_rx_done))
    else $error("load without char");
  // bus answers stand
  a_b_holds: assert property (o_bvalid && !i_bready
    |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  a_r_holds: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped");
  // mode gating
  a_master_sync: assert property (o_sync_master |-> o_sync_mode)
    else $error("master in async");
  a_tx_port: assert property (o_tx_run |-> o_port_active)
    else $error("tx with port off");
  a_rx_port: assert property (o_rx_run |-> o_port_active)
    else $error("rx with port off");
  a_sync_rx_wins: assert property (o_sync_mode && o_rx_run
    |-> !o_tx_run)
    else $error("tx beside sync rx");
  a_break_async: assert property (o_send_break |-> !o_sync_mode)
    else $error("break in sync");
  c_irq: cover property (o_rx_irq);
  c_break: cover property (o_send_break);
  c_slverr: cover property (o_bvalid && o_bresp == 2'h2);
endmodule // usb_ctrl_props

bind usb_ctrl usb_ctrl_props i_props (
  .i_clk, .i_resetn, .i_bready, .i_rready, .i_rx_done, .o_bvalid,
  .o_bresp, .o_rvalid, .o_rdata, .o_baud_tick, .o_port_active,
  .o_sync_mode, .o_sync_master, .o_tx_run, .o_rx_run, .o_rx_load,
  .o_rx_irq, .o_send_break
);

//--- dv/usb_ctrl_tb.sv
`timescale 1ns/1ps
`include "usb_consts.vh"
module usb_ctrl_tb;
  reg         i_clk     = 1'h0;
  reg         i_resetn  = 1'h0;
  reg  [4:0]  i_awaddr  = 5'h00;
  reg         i_awvalid = 1'h0;
  reg  [31:0] i_wdata   = 32'h0;
  reg         i_wvalid  = 1'h0;
  reg         i_bready  = 1'h0;
  reg  [4:0]  i_araddr  = 5'h00;
  reg         i_arvalid = 1'h0;
  reg         i_rready  = 1'h0;
  reg  [31:0] rdv;
  reg  [1:0]  rr, br;
  wire [31:0] o_rdata;
  wire [1:0]  o_bresp, o_rresp;
  wire [8:0]  i_rx_char;
  wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire        o_baud_tick, o_port_active, o_sync_mode, o_sync_master;
  wire        o_tx_run, o_tx_nine, o_tx_ninth, o_send_break, o_tx_idle_low;
  wire        o_rx_run, o_rx_level, o_rx_load, o_rx_irq, i_rx_pin;
  wire        i_tsr_empty, i_rx_done, i_rx_frame_err, i_rx_start;
  wire        i_fifo_full, i_data_read, i_break_done;
  wire        i_autobaud_done, i_autobaud_ovf;
  integer     errors = 0, compares = 0, loads = 0, irqs = 0, cycles = 0;
  // clock
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end
  usb_ctrl i_dut (
    .i_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'h1), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_rx_pin, .i_tsr_empty, .i_rx_done, .i_rx_char,
    .i_rx_frame_err, .i_rx_start, .i_fifo_full, .i_data_read,
    .i_break_done, .i_autobaud_done, .i_autobaud_ovf, .o_baud_tick,
    .o_port_active, .o_sync_mode, .o_sync_master, .o_tx_run, .o_tx_nine,
    .o_tx_ninth, .o_send_break, .o_tx_idle_low, .o_rx_run, .o_rx_level,
    .o_rx_load, .o_rx_irq
  );
  usb_far_model i_far (
    .i_clk, .i_brk(o_send_break), .o_pin(i_rx_pin), .o_empty(i_tsr_empty),
    .o_start(i_rx_start), .o_done(i_rx_done), .o_char(i_rx_char),
    .o_framing_error_flag(i_rx_frame_err), .o_full(i_fifo_full), .o_read(i_data_read),
    .o_brk_done(i_break_done), .o_ab_done(i_autobaud_done),
    .o_ab_ovf(i_autobaud_ovf)
  );
  // ----
  // bus and compare tasks
  // ----
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= {24'h0, d};
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do
      begin
        @(posedge i_clk);
        if (o_awready) i_awvalid <= 1'h0;
        if (o_wready) i_wvalid <= 1'h0;
      end while (!o_bvalid);
      br = o_bresp;
      i_bready <= 1'h0;
      repeat (2) @(posedge i_clk);
    end
  endtask
  task rchk(input [4:0] a, input [7:0] e, input string what);
    begin
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do
      begin
        @(posedge i_clk);
        if (o_arready) i_arvalid <= 1'h0;
      end while (!o_rvalid);
      rdv = o_rdata;
      rr = o_rresp;
      i_rready <= 1'h0;
      chk(rdv, {24'h0, e}, what);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    begin
      rchk(5'h00, 8'h02, "tx reset");
      rchk(5'h04, 8'h00, "rx reset");
      rchk(5'h08, 8'h40, "baud reset");
      rchk(5'h14, 8'h00, "unmapped");
      chk(rr, `USB_AXI_SLVERR, "rresp");
      wr(5'h14, 8'hff);
      chk(br, `USB_AXI_SLVERR, "bresp");
      $display("t_reset done");
    end
  endtask
  task meas(input [7:0] tx, input [7:0] bd, input [31:0] exp);
    reg [31:0] n;
    begin
      wr(5'h00, tx);
      wr(5'h08, bd);
      wr(5'h0c, 8'h02);
      while (!o_baud_tick) @(posedge i_clk);
      @(posedge i_clk);
      n = 1;
      while (!o_baud_tick)
      begin
        @(posedge i_clk);
        n = n + 1;
      end
      chk(n, exp, "period");
      chk(o_sync_mode, tx[4], "sync");
      chk(o_sync_master, tx[7] & tx[4], "master");
    end
  endtask
  task t_baud;
    begin
      wr(5'h04, 8'h90);
      wr(5'h10, 8'h01);
      meas(8'h00, 8'h00, 192);
      meas(8'h04, 8'h00, 48);
      meas(8'h00, 8'h08, 4144);
      meas(8'h04, 8'h08, 1036);
      meas(8'h94, 8'h00, 12);
      meas(8'h9c, 8'h08, 1036);
      $display("t_baud done");
    end
  endtask
  task t_rx;
    integer n;
    begin
      wr(5'h00, 8'h00);
      chk(o_rx_run, 1, "rx run");
      i_far.send_char(9'h1a5, 1'h1, 1'h0);
      rchk(5'h04, 8'h94, "framing_error_flag");
      i_far.send_char(9'h05a, 1'h1, 1'h1);
      rchk(5'h04, 8'h96, "overrun_error_flag");
      wr(5'h04, 8'h80);
      rchk(5'h04, 8'h84, "overrun_error_flag clr");
      wr(5'h04, 8'hd8);
      n = loads;
      i_far.send_char(9'h055, 1'h0, 1'h0);
      i_far.send_char(9'h155, 1'h0, 1'h0);
      chk(loads - n, 1, "addr det");
      rchk(5'h04, 8'hd9, "ninth");
      wr(5'h00, 8'h90);
      wr(5'h04, 8'ha0);
      i_far.send_char(9'h011, 1'h0, 1'h0);
      rchk(5'h04, 8'h80, "single clr");
      $display("t_rx done");
    end
  endtask
  task t_misc;
    integer m;
    begin
      wr(5'h00, 8'h28);
      chk(o_tx_run, 1, "tx run");
      repeat (6) @(posedge i_clk);
      rchk(5'h00, 8'h22, "break");
      wr(5'h00, 8'h61);
      chk({o_tx_nine, o_tx_ninth}, 2'h3, "nine");
      wr(5'h08, 8'h30);
      repeat (4) @(posedge i_clk);
      chk(o_rx_level, 0, "rx pol");
      chk(o_tx_idle_low, 1, "tx pol");
      wr(5'h08, 8'h02);
      m = irqs;
      i_far.wake_edges;
      chk(irqs - m, 1, "wake irq");
      rchk(5'h08, 8'h40, "wake clr");
      wr(5'h08, 8'h01);
      i_far.autobaud;
      rchk(5'h08, 8'hc0, "autobaud");
      wr(5'h08, 8'h00);
      rchk(5'h08, 8'h40, "ovf clr");
      wr(5'h04, 8'h00);
      chk({o_port_active, o_rx_run, o_tx_run}, 3'h0, "port off");
      $display("t_misc done");
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // event counts and hang guard
  always @(posedge i_clk)
  begin
    loads <= loads + o_rx_load;
    irqs <= irqs + o_rx_irq;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      stop_test;
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'h1;
    t_reset;
    t_baud;
    t_rx;
    t_misc;
    stop_test;
  end
endmodule // usb_ctrl_tb

//--- dv/usb_far_model.sv
`timescale 1ns/1ps
// ----
// far-side shifter and buffer stand-in
// ----
module usb_far_model (
  input  wire       i_clk,             // system clock
  input  wire       i_brk,             // break asked
  output reg        o_pin = 1'h1,      // receive line
  output reg        o_empty = 1'h1,    // shifter empty
  output reg        o_start = 1'h0,    // start seen
  output reg        o_done = 1'h0,     // char done
  output reg  [8:0] o_char = 9'h000,   // char value
  output reg        o_framing_error_flag = 1'h0,     // stop low
  output reg        o_full = 1'h0,     // buffer full
  output reg        o_read = 1'h0,     // data read
  output reg        o_brk_done = 1'h0, // break over
  output reg        o_ab_done = 1'h0,  // autobaud done
  output reg        o_ab_ovf = 1'h0    // autobaud ovf
);
  always @(posedge i_clk)
  begin
    o_brk_done <= i_brk & ~o_brk_done;
    o_empty <= ~i_brk;
  end
  task send_char(input [8:0] c, input f, input full);
    begin
      @(posedge i_clk);
      o_start <= 1'h1;
      o_read <= 1'h1;
      @(posedge i_clk);
      o_start <= 1'h0;
      o_read <= 1'h0;
      o_done <= 1'h1;
      o_char <= c;
      o_framing_error_flag <= f;
      o_full <= full;
      @(posedge i_clk);
      o_done <= 1'h0;
      o_char <= ~c;
      o_framing_error_flag <= ~f;
      o_full <= 1'h0;
      repeat (2) @(posedge i_clk);
    end
  endtask
  task wake_edges;
    begin
      @(posedge i_clk);
      o_pin <= 1'h0;
      repeat (8) @(posedge i_clk);
      o_pin <= 1'h1;
      repeat (8) @(posedge i_clk);
    end
  endtask
  task autobaud;
    begin
      @(posedge i_clk);
      o_ab_done <= 1'h1;
      o_ab_ovf <= 1'h1;
      @(posedge i_clk);
      o_ab_done <= 1'h0;
      o_ab_ovf <= 1'h0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule // usb_far_model

//--- src/usb_baud_gen.v
`timescale 1ns/1ps
`include "usb_consts.vh"
// ------------------------------------------------------------
// baud timer: period counter plus multiplier prescaler
// ------------------------------------------------------------
module usb_baud_gen (
  input  wire        i_clk,     // system clock
  input  wire        i_resetn,  // sync reset, low
  input  wire        i_clear,   // restart timer
  input  wire [15:0] i_period,  // n, period value
  input  wire [6:0]  i_mult,    // clocks per tick unit
  output reg         o_tick     // one pulse per bit time
);
  reg [15:0] cnt_q;
  reg [6:0]  pre_q;

  // prescale then count n+1 units
  always @(posedge i_clk)
  begin
    if (!i_resetn || i_clear)
    begin
      cnt_q  <= 16'h0000;
      pre_q  <= 7'h00;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (pre_q == i_mult - 7'h01)
      begin
        pre_q <= 7'h00;
        if (cnt_q >= i_period)
        begin
          cnt_q  <= 16'h0000;
          o_tick <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
      else
        pre_q <= pre_q + 7'h01;
    end
  end
endmodule // usb_baud_gen

//--- src/usb_consts.vh
`ifndef USB_CONSTS_VH
`define USB_CONSTS_VH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define USB_ADDR_TX_CTRL     4'h0
`define USB_ADDR_RX_CTRL     4'h4
`define USB_ADDR_BAUD_CTRL   4'h8
`define USB_ADDR_PERIOD_LO   4'hc
// period high byte sits at 0x10
`define USB_ADDR_PERIOD_HI   5'h10
// ------------------------------------------------------------
// transmit control fields
// ------------------------------------------------------------
`define USB_TX_CLKSRC   7
`define USB_TX_NINE     6
`define USB_TX_EN       5
`define USB_TX_SYNC     4
`define USB_TX_BREAK    3
`define USB_TX_HIGHSPD  2
`define USB_TX_EMPTY    1
`define USB_TX_NINTH    0
// ------------------------------------------------------------
// receive control fields
// ------------------------------------------------------------
`define USB_RX_PORTEN   7
`define USB_RX_NINE     6
`define USB_RX_SINGLE   5
`define USB_RX_CONT     4
`define USB_RX_ADDRDET  3
`define USB_RX_FRAMERR  2
`define USB_RX_OVERRUN  1
`define USB_RX_NINTH    0
// ------------------------------------------------------------
// baud control fields
// ------------------------------------------------------------
`define USB_BD_ABOVF    7
`define USB_BD_IDLE     6
`define USB_BD_RXPOL    5
`define USB_BD_TXPOL    4
`define USB_BD_WIDE     3
`define USB_BD_WAKE     1
`define USB_BD_AUTOBAUD 0
// ------------------------------------------------------------
// reset values and divisors
// ------------------------------------------------------------
`define USB_TX_RESET    8'h02
`define USB_RX_RESET    8'h00
`define USB_BD_RESET    8'h40
`define USB_DIV_SLOW8   7'h40
`define USB_DIV_MID     7'h10
`define USB_DIV_FAST    7'h04
`define USB_AXI_OKAY    2'h0
`define USB_AXI_SLVERR  2'h2
`endif

//--- src/usb_ctrl.v
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "usb_consts.vh"
module usb_ctrl (
  input  wire        i_clk,          // system clock
  input  wire        i_resetn,       // sync reset, low
  input  wire [4:0]  i_awaddr,       // write address
  input  wire        i_awvalid,      // write address valid
  output reg         o_awready,      // write address ready
  input  wire [31:0] i_wdata,        // write data
  input  wire [3:0]  i_wstrb,        // byte strobes
  input  wire        i_wvalid,       // write data valid
  output reg         o_wready,       // write data ready
  output reg  [1:0]  o_bresp,        // write response
  output reg         o_bvalid,       // write response valid
  input  wire        i_bready,       // write response ready
  input  wire [4:0]  i_araddr,       // read address
  input  wire        i_arvalid,      // read address valid
  output reg         o_arready,      // read address ready
  output reg  [31:0] o_rdata,        // read data
  output reg  [1:0]  o_rresp,        // read response
  output reg         o_rvalid,       // read data valid
  input  wire        i_rready,       // read data ready
  input  wire        i_rx_pin,       // receive / sync data pin
  input  wire        i_tsr_empty,    // shift register empty
  input  wire        i_rx_done,      // character landed in shift reg
  input  wire [8:0]  i_rx_char,      // received character
  input  wire        i_rx_frame_err, // stop bit was low
  input  wire        i_rx_start,     // start bit detected
  input  wire        i_fifo_full,    // receive buffer full
  input  wire        i_data_read,    // receive data register read
  input  wire        i_break_done,   // break character finished
  input  wire        i_autobaud_done,// autobaud sequence done
  input  wire        i_autobaud_ovf, // autobaud timer overflow
  output reg         o_baud_tick,    // bit-rate tick
  output reg         o_port_active,  // pins owned by port
  output reg         o_sync_mode,    // synchronous operation
  output reg         o_sync_master,  // drive serial clock
  output reg         o_tx_run,       // transmitter may send
  output reg         o_tx_nine,      // nine-bit transmit
  output reg         o_tx_ninth,     // ninth transmit bit
  output reg         o_send_break,   // next frame is break
  output reg         o_tx_idle_low,  // async idle level low
  output reg         o_rx_run,       // receiver enabled
  output reg         o_rx_level,     // polarity-corrected data
  output reg         o_rx_load,      // load receive buffer
  output reg         o_rx_irq        // receive interrupt flag set
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  reg  [7:0]  tx_q;
  reg  [7:0]  rx_q;
  reg  [7:0]  bd_q;
  reg  [7:0]  per_lo_q;
  reg  [7:0]  per_hi_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [4:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         frm_pend_q;
  reg         wake_arm_q;
  wire        rx_level;
  wire        rx_fall;
  wire        rx_rise;
  wire        tick;
  wire        do_write;
  wire        period_wr;
  wire [15:0] period;
  reg  [6:0]  mult;
  wire        sync_m;
  wire        wake_act;

  // mapped address check
  function addr_ok;
    input [4:0] a;
    begin
      addr_ok = (a == {1'b0, `USB_ADDR_TX_CTRL})
             || (a == {1'b0, `USB_ADDR_RX_CTRL})
             || (a == {1'b0, `USB_ADDR_BAUD_CTRL})
             || (a == {1'b0, `USB_ADDR_PERIOD_LO})
             || (a == `USB_ADDR_PERIOD_HI);
    end
  endfunction

  // masked byte write of lane zero
  function [7:0] wr_byte;
    input [7:0] old;
    input [7:0] mask;
    input [31:0] d;
    input [3:0]  s;
    begin
      wr_byte = s[0] ? ((old & ~mask) | (d[7:0] & mask)) : old;
    end
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  usb_rx_front u_front (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_rx_pin),
    .i_invert (bd_q[`USB_BD_RXPOL]),
    .o_level  (rx_level),
    .o_fall   (rx_fall),
    .o_rise   (rx_rise)
  );

  usb_baud_gen u_baud (
    .i_clk    (i_clk),
    .i_resetn (i_resetn & rx_q[`USB_RX_PORTEN]),
    .i_clear  (period_wr),
    .i_period (period),
    .i_mult   (mult),
    .o_tick   (tick)
  );

  // ------------------------------------------------------------
  // decode and divisor select
  // ------------------------------------------------------------
  assign do_write  = aw_got_q && w_got_q && !o_bvalid;
  assign period_wr = do_write && w_strb_q[0]
                  && ((aw_addr_q == {1'b0, `USB_ADDR_PERIOD_LO})
                   || (aw_addr_q == `USB_ADDR_PERIOD_HI));
  assign period = bd_q[`USB_BD_WIDE] ? {per_hi_q, per_lo_q}
                                     : {8'h00, per_lo_q};
  assign sync_m = tx_q[`USB_TX_SYNC] & tx_q[`USB_TX_CLKSRC];
  assign wake_act = bd_q[`USB_BD_WAKE] & ~tx_q[`USB_TX_SYNC];

  always @*
  begin
    mult = `USB_DIV_SLOW8;
    if (tx_q[`USB_TX_SYNC])
      mult = `USB_DIV_FAST;
    else if (tx_q[`USB_TX_HIGHSPD] && bd_q[`USB_BD_WIDE])
      mult = `USB_DIV_FAST;
    else if (tx_q[`USB_TX_HIGHSPD] || bd_q[`USB_BD_WIDE])
      mult = `USB_DIV_MID;
  end

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `USB_AXI_OKAY;
    end
    else
    begin
      o_awready <= !aw_got_q && !o_awready && !o_bvalid;
      o_wready  <= !w_got_q && !o_wready && !o_bvalid;
      if (i_awvalid && o_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= {i_awaddr[4:2], 2'b00};
      end
      if (i_wvalid && o_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= addr_ok(aw_addr_q) ? `USB_AXI_OKAY : `USB_AXI_SLVERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `USB_AXI_OKAY;
    end
    else
    begin
      o_arready <= !o_arready && !o_rvalid;
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= addr_ok({i_araddr[4:2], 2'b00}) ? `USB_AXI_OKAY
                                                    : `USB_AXI_SLVERR;
        case ({i_araddr[4:2], 2'b00})
          {1'b0, `USB_ADDR_TX_CTRL}:   o_rdata <= {24'h0, tx_q};
          {1'b0, `USB_ADDR_RX_CTRL}:   o_rdata <= {24'h0, rx_q};
          {1'b0, `USB_ADDR_BAUD_CTRL}: o_rdata <= {24'h0, bd_q};
          {1'b0, `USB_ADDR_PERIOD_LO}: o_rdata <= {24'h0, per_lo_q};
          `USB_ADDR_PERIOD_HI:         o_rdata <= {24'h0, per_hi_q};
          default:                     o_rdata <= 32'h00000000;
        endcase
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control and status registers
  // ------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      tx_q       <= `USB_TX_RESET;
      rx_q       <= `USB_RX_RESET;
      bd_q       <= `USB_BD_RESET;
      per_lo_q   <= 8'h00;
      per_hi_q   <= 8'h00;
      frm_pend_q <= 1'b0;
      wake_arm_q <= 1'b0;
    end
    else
    begin
      // software writes, writable bits only
      if (do_write)
        case (aw_addr_q)
          {1'b0, `USB_ADDR_TX_CTRL}:
            tx_q <= wr_byte(tx_q, 8'hfd, w_data_q, w_strb_q);
          {1'b0, `USB_ADDR_RX_CTRL}:
          begin
            rx_q <= wr_byte(rx_q, 8'hf8, w_data_q, w_strb_q);
            if (w_strb_q[0] && !w_data_q[`USB_RX_CONT])
              rx_q[`USB_RX_OVERRUN] <= 1'b0;
          end
          {1'b0, `USB_ADDR_BAUD_CTRL}:
            bd_q <= wr_byte(bd_q, 8'hbb, w_data_q, w_strb_q);
          {1'b0, `USB_ADDR_PERIOD_LO}:
            per_lo_q <= wr_byte(per_lo_q, 8'hff, w_data_q, w_strb_q);
          `USB_ADDR_PERIOD_HI:
            per_hi_q <= wr_byte(per_hi_q, 8'hff, w_data_q, w_strb_q);
          default:
            ;
        endcase
      tx_q[`USB_TX_EMPTY] <= i_tsr_empty;
      if (i_break_done)
        tx_q[`USB_TX_BREAK] <= 1'b0;
      if (i_rx_done && sync_m)
        rx_q[`USB_RX_SINGLE] <= 1'b0;
      if (i_rx_done && i_fifo_full && o_rx_run)
        rx_q[`USB_RX_OVERRUN] <= 1'b1;
      // framing updated on each char while clear, once set only on read then char
      if (i_rx_done && o_rx_run && !wake_act
          && (frm_pend_q || !rx_q[`USB_RX_FRAMERR]))
      begin
        rx_q[`USB_RX_FRAMERR] <= i_rx_frame_err;
        frm_pend_q            <= 1'b0;
        rx_q[`USB_RX_NINTH]   <= rx_q[`USB_RX_NINE] & i_rx_char[8];
      end
      // a read in the same cycle keeps the pending mark
      if (i_data_read)
        frm_pend_q <= 1'b1;
      if (!tx_q[`USB_TX_SYNC])
      begin
        if (i_rx_start)
          bd_q[`USB_BD_IDLE] <= 1'b0;
        else if (i_rx_done)
          bd_q[`USB_BD_IDLE] <= 1'b1;
      end
      if (i_autobaud_ovf && !tx_q[`USB_TX_SYNC])
        bd_q[`USB_BD_ABOVF] <= 1'b1;
      if (i_autobaud_done)
        bd_q[`USB_BD_AUTOBAUD] <= 1'b0;
      // wakeup arm on fall, clear on rise
      if (wake_act && rx_fall)
        wake_arm_q <= 1'b1;
      if (wake_arm_q && rx_rise)
      begin
        bd_q[`USB_BD_WAKE] <= 1'b0;
        wake_arm_q         <= 1'b0;
      end
      // disabled port holds overrun, framing, idle and wake arm in reset
      if (!rx_q[`USB_RX_PORTEN])
      begin
        rx_q[`USB_RX_OVERRUN] <= 1'b0;
        rx_q[`USB_RX_FRAMERR] <= 1'b0;
        bd_q[`USB_BD_IDLE]    <= 1'b1;
        wake_arm_q            <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs to the datapath
  // ------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_baud_tick   <= 1'b0;
      o_port_active <= 1'b0;
      o_sync_mode   <= 1'b0;
      o_sync_master <= 1'b0;
      o_tx_run      <= 1'b0;
      o_tx_nine     <= 1'b0;
      o_tx_ninth    <= 1'b0;
      o_send_break  <= 1'b0;
      o_tx_idle_low <= 1'b0;
      o_rx_run      <= 1'b0;
      o_rx_level    <= 1'b1;
      o_rx_load     <= 1'b0;
      o_rx_irq      <= 1'b0;
    end
    else
    begin
      o_baud_tick   <= tick;
      o_port_active <= rx_q[`USB_RX_PORTEN];
      o_sync_mode   <= tx_q[`USB_TX_SYNC];
      o_sync_master <= sync_m;
      o_tx_run      <= rx_q[`USB_RX_PORTEN] & tx_q[`USB_TX_EN]
                     & ~(tx_q[`USB_TX_SYNC]
                         & (rx_q[`USB_RX_SINGLE] | rx_q[`USB_RX_CONT]));
      o_tx_nine     <= tx_q[`USB_TX_NINE];
      o_tx_ninth    <= tx_q[`USB_TX_NINE] & tx_q[`USB_TX_NINTH];
      o_send_break  <= tx_q[`USB_TX_BREAK] & ~tx_q[`USB_TX_SYNC];
      // idle low, or sync edge choice
      o_tx_idle_low <= bd_q[`USB_BD_TXPOL];
      o_rx_run      <= rx_q[`USB_RX_PORTEN]
                     & (rx_q[`USB_RX_CONT]
                        | (sync_m & rx_q[`USB_RX_SINGLE]));
      o_rx_level    <= rx_level;
      o_rx_load     <= i_rx_done && o_rx_run && !wake_act
                    && !(rx_q[`USB_RX_ADDRDET] && rx_q[`USB_RX_NINE]
                         && !tx_q[`USB_TX_SYNC] && !i_rx_char[8]);
      o_rx_irq      <= (i_rx_done && o_rx_run && !wake_act
                    && !(rx_q[`USB_RX_ADDRDET] && rx_q[`USB_RX_NINE]
                         && !tx_q[`USB_TX_SYNC] && !i_rx_char[8]))
                    || (wake_act && rx_fall && rx_q[`USB_RX_PORTEN]);
    end
  end
endmodule // usb_ctrl

//--- src/usb_rx_front.v
`timescale 1ns/1ps
`include "usb_consts.vh"
// ------------------------------------------------------------
// two-stage pin synchroniser with polarity and edges
// ------------------------------------------------------------
module usb_rx_front (
  input  wire i_clk,     // system clock
  input  wire i_resetn,  // sync reset, low
  input  wire i_pin,     // raw receive pin
  input  wire i_invert,  // receive polarity
  output reg  o_level,   // synced, polarity fixed
  output reg  o_fall,    // falling edge pulse
  output reg  o_rise     // rising edge pulse
);
  reg meta_q;
  reg sync_q;

  // synchroniser, then edge detect on second stage
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      meta_q  <= 1'b1;
      sync_q  <= 1'b1;
      o_level <= 1'b1;
      o_fall  <= 1'b0;
      o_rise  <= 1'b0;
    end
    else
    begin
      meta_q  <= i_pin;
      sync_q  <= meta_q;
      o_level <= sync_q ^ i_invert;
      o_fall  <= o_level & ~(sync_q ^ i_invert);
      o_rise  <= ~o_level & (sync_q ^ i_invert);
    end
  end
endmodule // usb_rx_front
